// ==== boot_map_defines.svh ====
// Purpose: offsets, field positions, reset values and bounds
// Assumes: 32-bit APB data, byte addresses, one word per register
// Notes: flash word addresses are program-counter words
`ifndef BOOT_MAP_DEFINES_SVH
`define BOOT_MAP_DEFINES_SVH

// register byte offsets
`define OFS_POINTER 12'h000
`define OFS_EXT_PAGE 12'h004
`define OFS_COMMAND 12'h008
`define OFS_STATUS 12'h00c
`define OFS_BOOT_START 12'h010
`define OFS_APP_END 12'h014
`define OFS_PAGE 12'h018
`define OFS_WORD 12'h01c
`define OFS_LOAD_DATA 12'h020

// status bit positions
`define ST_BUSY 0
`define ST_RWW_BUSY 1
`define ST_HALT 2
`define ST_CMD_ERR 3
`define ST_WIDE 4

// pointer layout
`define PTR_BYTE_SEL 0
`define PTR_WORD_LO 1
`define PTR_WORD_HI 7
`define PTR_PAGE_LO 8
`define PAGE_WORDS 128
`define WORD_BITS 7

// flash geometry per variant
`define TOP_32K 16'h7fff
`define TOP_64K 16'hffff
`define NO_READ_WHILE_WRITE_AREA_START_32K 16'h7000
`define NO_READ_WHILE_WRITE_AREA_START_64K 16'hf000
`define NO_READ_WHILE_WRITE_AREA_PAGES 32
`define RWW_PAGES_32K 224
`define RWW_PAGES_64K 480

// boot section starts, fuse code 11/10/01/00
`define BOOT_32K_3 16'h7e00
`define BOOT_32K_2 16'h7c00
`define BOOT_32K_1 16'h7800
`define BOOT_32K_0 16'h7000
`define BOOT_64K_3 16'hfe00
`define BOOT_64K_2 16'hfc00
`define BOOT_64K_1 16'hf800
`define BOOT_64K_0 16'hf000

// reset values
`define POINTER_RST 16'h0000
`define FUSE_RST 2'h0

`endif

// ==== boot_map_pkg.sv ====
// Purpose: types shared by the boot section decoder
// Assumes: nothing beyond the defines header
// Notes: command codes are written to the command register
package boot_map_pkg;
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_FILL = 3'b001,
        OP_ERASE = 3'b010,
        OP_WRITE = 3'b011,
        OP_REENABLE = 3'b100,
        OP_LOAD = 3'b101
    } op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ISSUE = 2'b01,
        ST_WAIT = 2'b10
    } seq_state_t;
endpackage

// ==== boot_map_properties.sv ====
// Purpose: port-level properties of the boot section decoder
// Assumes: fuse straps change only while reset is low
// Notes: bound to every instance of the decoder
`timescale 1ns/1ps
module boot_map_properties
    import boot_map_pkg::*;
#(
    parameter bit wide = 1'b0
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // fuse straps
    input wire logic boot_size_fuse_hi,
    input wire logic boot_size_fuse_lo,
    // flash and cpu
    input wire logic flash_req,
    input wire logic [2:0] flash_op,
    input wire logic [8:0] flash_page,
    input wire logic [6:0] flash_word,
    input wire logic flash_done,
    input wire logic cpu_halt,
    input wire logic rww_blocked,
    input wire logic [15:0] boot_reset_vector
);
    localparam int no_read_while_write_area_page = wide ? 480 : 224;
    logic [1:0] up_q;
    logic [16:0] exp_vec;
    assign exp_vec = (wide ? 17'h10000 : 17'h08000)
        - (17'd512 << ~{boot_size_fuse_hi, boot_size_fuse_lo});
    // vector is only settled two edges after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_q <= 2'd0;
        end else if (up_q != 2'd3) begin
            up_q <= up_q + 2'd1;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_prog;
        flash_req && (flash_op == OP_ERASE || flash_op == OP_WRITE);
    endsequence
    sequence s_setup;
        psel && !penable;
    endsequence
    a_vector_fuse: assert property (
        up_q >= 2'd2 |-> boot_reset_vector == exp_vec[15:0])
        else $error("boot vector differs from fuse code");
    a_halt_no_read_while_write_area: assert property (
        s_prog ##0 flash_page >= no_read_while_write_area_page |-> cpu_halt)
        else $error("no halt for protected page");
    a_rww_block: assert property (
        s_prog ##0 flash_page < no_read_while_write_area_page |-> rww_blocked && !cpu_halt)
        else $error("rww page not blocked");
    a_halt_hold: assert property (
        cpu_halt && !flash_done |=> cpu_halt)
        else $error("halt dropped early");
    a_halt_end: assert property (
        cpu_halt && flash_done |=> !cpu_halt)
        else $error("halt outlived done");
    a_page_top: assert property (
        flash_req && !wide |-> !flash_page[8])
        else $error("page bit 8 set in small variant");
    a_write_word: assert property (
        flash_req && flash_op == OP_WRITE |-> flash_word == 7'h0)
        else $error("page write with word bits");
    a_req_pulse: assert property (
        flash_req |=> !flash_req [*2])
        else $error("request longer than one cycle");
    a_apb_answer: assert property (
        s_setup |=> pready ##1 !pready)
        else $error("ready not one cycle after setup");
    a_unmapped_err: assert property (
        s_setup ##1 paddr > 12'h020 |-> pready && pslverr)
        else $error("no error on unmapped address");
endmodule
bind boot_section_address_decoder boot_map_properties #(.wide(wide))
    boot_map_properties_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .boot_size_fuse_hi(boot_size_fuse_hi),
    .boot_size_fuse_lo(boot_size_fuse_lo),
    .flash_req(flash_req), .flash_op(flash_op), .flash_page(flash_page),
    .flash_word(flash_word), .flash_done(flash_done), .cpu_halt(cpu_halt),
    .rww_blocked(rww_blocked), .boot_reset_vector(boot_reset_vector));

// ==== boot_section_address_decoder.sv ====
// Purpose: boot section decoder and self-programming sequencer
// Assumes: flash macro answers every request with flash_done
// Notes: APB slave, no wait state on any transfer
`timescale 1ns/1ps
`include "boot_map_defines.svh"

// Behaviour
// - fuse code picks boot size 512..4096
// - 32K: boot start per code, ends 7fff
// - 64K: boot start per code, ends ffff
// - 32K: rww below 7000, no_read_while_write_area above
// - 64K: rww below f000, no_read_while_write_area above
// - no_read_while_write_area area fixed at 32 pages
// - 32K variant uses 15-bit counter
// - 64K variant uses 16-bit counter
// - 128-word pages, low seven bits word
// - buffer fill word from pointer 7:1
// - page number from pointer top bits
// - counter bit n is pointer bit n+1
// - pointer bit 0 zero for stores; byte select
// - 64K: pointer bit 16 from extended page register, 32K: tied to zero
// - busy flag blocks read-while-write area
// - halt cpu during no_read_while_write_area erase or write
module boot_section_address_decoder
    import boot_map_pkg::*;
#(
    parameter bit wide = 1'b0
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // boot size fuse straps
    input wire logic boot_size_fuse_hi,
    input wire logic boot_size_fuse_lo,
    // flash macro
    output logic flash_req,
    output logic [2:0] flash_op,
    output logic [8:0] flash_page,
    output logic [6:0] flash_word,
    input wire logic flash_done,
    input wire logic [15:0] flash_rdata,
    // cpu side
    output logic cpu_halt,
    output logic rww_blocked,
    output logic [15:0] boot_reset_vector
);
    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        return a == o;
    endfunction

    region_map_if mif();

    region_map #(
        .wide(wide)
    ) u_map (
        .m(mif)
    );

    logic [15:0] pointer_q;
    logic ext_page_q;
    logic [1:0] fuse_q;
    logic fuse_taken_q;
    seq_state_t state_q;
    op_t op_q;
    logic rww_busy_q;
    logic halt_q;
    logic cmd_err_q;
    logic [7:0] load_data_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic req_q;
    logic [8:0] page_q;
    logic [6:0] word_q;
    logic [15:0] vector_q;
    logic setup;
    logic wr_en;
    logic mapped;
    logic cmd_wr;
    logic cmd_ok;
    logic err_set;
    logic err_clr;
    op_t cmd_op;
    logic [31:0] rd_d;
    logic accept;
    logic byte_sel_q;

    // bit 16 only exists in the wide variant
    assign mif.pointer = {wide ? ext_page_q : 1'b0, pointer_q};
    assign mif.fuse = fuse_q;

    // a setup counts once per transfer, never while the answer stands
    assign setup = psel && !penable && !pready_q;
    assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q;
    assign cmd_wr = wr_en && hit(paddr, `OFS_COMMAND);
    assign cmd_op = op_t'(pwdata[2:0]);

    always_comb begin
        mapped = 1'b1;
        if (hit(paddr, `OFS_POINTER)) begin
            mapped = 1'b1;
        end else if (hit(paddr, `OFS_EXT_PAGE)) begin
            mapped = 1'b1;
        end else if (hit(paddr, `OFS_COMMAND)) begin
            mapped = 1'b1;
        end else if (hit(paddr, `OFS_STATUS)) begin
            mapped = 1'b1;
        end else if (hit(paddr, `OFS_BOOT_START)) begin
            mapped = 1'b1;
        end else if (hit(paddr, `OFS_APP_END)) begin
            mapped = 1'b1;
        end else if (hit(paddr, `OFS_PAGE)) begin
            mapped = 1'b1;
        end else if (hit(paddr, `OFS_WORD)) begin
            mapped = 1'b1;
        end else if (hit(paddr, `OFS_LOAD_DATA)) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        if (hit(paddr, `OFS_POINTER)) begin
            rd_d = {16'h0000, pointer_q};
        end else if (hit(paddr, `OFS_EXT_PAGE)) begin
            rd_d = {31'h0000_0000, ext_page_q};
        end else if (hit(paddr, `OFS_STATUS)) begin
            rd_d[`ST_BUSY] = state_q != ST_IDLE;
            rd_d[`ST_RWW_BUSY] = rww_busy_q;
            rd_d[`ST_HALT] = halt_q;
            rd_d[`ST_CMD_ERR] = cmd_err_q;
            rd_d[`ST_WIDE] = wide;
        end else if (hit(paddr, `OFS_BOOT_START)) begin
            rd_d = {16'h0000, mif.boot_start};
        end else if (hit(paddr, `OFS_APP_END)) begin
            rd_d = {16'h0000, mif.app_end};
        end else if (hit(paddr, `OFS_PAGE)) begin
            rd_d = {23'h00_0000, mif.page_number};
        end else if (hit(paddr, `OFS_WORD)) begin
            rd_d = {25'h000_0000, mif.word_in_page_index};
        end else if (hit(paddr, `OFS_LOAD_DATA)) begin
            rd_d = {24'h00_0000, load_data_q};
        end else begin
            rd_d = 32'h0000_0000;
        end
    end

    // command acceptance: idle, and store commands need byte bit clear
    always_comb begin
        cmd_ok = 1'b0;
        if (state_q == ST_IDLE) begin
            case (cmd_op)
                OP_FILL, OP_ERASE, OP_WRITE, OP_REENABLE: begin
                    cmd_ok = !pointer_q[`PTR_BYTE_SEL];
                end
                OP_LOAD: begin
                    // no reads of the busy area until a re-enable or fill command
                    cmd_ok = !(rww_busy_q && !mif.in_no_read_while_write_area);
                end
                default: begin
                    cmd_ok = 1'b0;
                end
            endcase
        end
    end

    assign err_set = cmd_wr && !cmd_ok;
    assign err_clr = wr_en && hit(paddr, `OFS_STATUS)
                     && pwdata[`ST_CMD_ERR];

    // one accepted command per idle period
    assign accept = state_q == ST_IDLE && cmd_wr && cmd_ok;

    // apb answer, no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= setup;
            if (setup) begin
                pslverr_q <= !mapped;
                prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
            end else if (pready_q) begin
                pslverr_q <= 1'b0;
            end
        end
    end

    // software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pointer_q <= `POINTER_RST;
            ext_page_q <= 1'b0;
        end else if (wr_en && hit(paddr, `OFS_POINTER)) begin
            pointer_q <= pwdata[15:0];
        end else if (wr_en && hit(paddr, `OFS_EXT_PAGE)) begin
            ext_page_q <= pwdata[0];
        end
    end

    // fuse straps caught once after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fuse_q <= `FUSE_RST;
            fuse_taken_q <= 1'b0;
        end else if (!fuse_taken_q) begin
            fuse_q <= {boot_size_fuse_hi, boot_size_fuse_lo};
            fuse_taken_q <= 1'b1;
        end
    end

    // sticky refusal flag, a new refusal beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_err_q <= 1'b0;
        end else if (err_set) begin
            cmd_err_q <= 1'b1;
        end else if (err_clr) begin
            cmd_err_q <= 1'b0;
        end
    end

    // request sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            op_q <= OP_NONE;
            req_q <= 1'b0;
            page_q <= 9'h000;
            word_q <= 7'h00;
        end else begin
            req_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (cmd_wr && cmd_ok) begin
                        op_q <= cmd_op;
                        page_q <= mif.page_number;
                        // page write forces word bits to zero
                        word_q <= (cmd_op == OP_WRITE) ? 7'h00
                                  : mif.word_in_page_index;
                        state_q <= ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    req_q <= 1'b1;
                    state_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (flash_done) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // busy flag over the read-while-write area
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rww_busy_q <= 1'b0;
        end else if (state_q == ST_IDLE && cmd_wr && cmd_ok) begin
            if ((cmd_op == OP_ERASE || cmd_op == OP_WRITE)
                && !mif.in_no_read_while_write_area) begin
                rww_busy_q <= 1'b1;
            end else if (cmd_op == OP_FILL || cmd_op == OP_REENABLE) begin
                // re-enable only accepted when idle, so never mid-write
                rww_busy_q <= 1'b0;
            end
        end
    end

    // cpu halt while no_read_while_write_area erase or write is outstanding
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_q <= 1'b0;
        end else if (state_q == ST_IDLE && cmd_wr && cmd_ok
                     && (cmd_op == OP_ERASE || cmd_op == OP_WRITE)
                     && mif.in_no_read_while_write_area) begin
            halt_q <= 1'b1;
        end else if (state_q == ST_WAIT && flash_done) begin
            halt_q <= 1'b0;
        end
    end

    // byte choice frozen at acceptance; pointer may move meanwhile
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            byte_sel_q <= 1'b0;
        end else if (accept) begin
            byte_sel_q <= pointer_q[`PTR_BYTE_SEL];
        end
    end

    // load result, pointer bit 0 picks the byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_data_q <= 8'h00;
        end else if (state_q == ST_WAIT && flash_done && op_q == OP_LOAD) begin
            load_data_q <= byte_sel_q ? flash_rdata[15:8]
                                      : flash_rdata[7:0];
        end
    end

    // boot reset vector, counter width follows the variant
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vector_q <= 16'h0000;
        end else begin
            vector_q <= wide ? mif.boot_start
                             : {1'b0, mif.boot_start[14:0]};
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign flash_req = req_q;
    assign flash_op = op_q;
    assign flash_page = page_q;
    assign flash_word = word_q;
    assign cpu_halt = halt_q;
    assign rww_blocked = rww_busy_q;
    assign boot_reset_vector = vector_q;
endmodule

// ==== boot_section_address_decoder_tb.sv ====
// Purpose: self-checking bench for both size variants side by side
// Assumes: both instances answer apb in the same cycle
// Notes: expectations come from an integer model
`timescale 1ns/1ps
`include "boot_map_defines.svh"
module boot_section_address_decoder_tb
    import boot_map_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, fz_hi, fz_lo;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    wire [31:0] prdata [2];
    wire pready [2], pslverr [2], f_req [2], f_done [2], halt [2], rwwb [2];
    wire [2:0] f_op [2];
    wire [8:0] f_page [2];
    wire [6:0] f_word [2];
    wire [15:0] f_rd [2], vec [2];
    logic [31:0] got [2];
    logic got_err [2];
    logic [16:0] p;
    logic [15:0] wv;
    int n_mismatch = 0, n_checks = 0, st;
    int m_rww [2], m_err [2], nr [2], rf [2];
    logic [2:0] t_op [10] = '{OP_ERASE, OP_LOAD, OP_REENABLE, OP_FILL,
        OP_WRITE, OP_ERASE, OP_FILL, OP_LOAD, OP_REENABLE, OP_LOAD};
    logic [16:0] t_ptr [10] = '{17'h02000, 17'h02001, 17'h00000, 17'h020a4,
        17'h1f000,
        17'h0e000, 17'h00003, 17'h01235, 17'h00000, 17'h1ffff};

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    for (genvar w = 0; w < 2; w++) begin : g_var
        boot_section_address_decoder #(.wide(w == 1))
            boot_section_address_decoder_inst (
            .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
            .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
            .prdata(prdata[w]), .pready(pready[w]), .pslverr(pslverr[w]),
            .boot_size_fuse_hi(fz_hi), .boot_size_fuse_lo(fz_lo),
            .flash_req(f_req[w]), .flash_op(f_op[w]), .flash_page(f_page[w]),
            .flash_word(f_word[w]), .flash_done(f_done[w]),
            .flash_rdata(f_rd[w]), .cpu_halt(halt[w]),
            .rww_blocked(rwwb[w]), .boot_reset_vector(vec[w]));
        flash_partner flash_partner_inst (.pclk(pclk), .flash_req(f_req[w]),
            .flash_page(f_page[w]), .flash_word(f_word[w]),
            .flash_done(f_done[w]), .flash_rdata(f_rd[w]));
    end

    task chk(input logic [31:0] g, input logic [31:0] e, input string m);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
        end
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready[0] !== 1'b1) @(posedge pclk);
        for (int w = 0; w < 2; w++) begin
            got[w] = prdata[w];
            got_err[w] = pslverr[w];
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    function int page_of(int w, logic [16:0] v);
        return w ? v[16:8] : v[15:8];
    endfunction

    initial begin
        #(25 * 20000);
        n_mismatch++;
        complete_run();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        void'($urandom(32'hc43d38fd));
        for (int c = 0; c < 4; c++) begin
            presetn <= 1'b0;
            {fz_hi, fz_lo} <= c[1:0];
            repeat (10) @(posedge pclk);
            presetn <= 1'b1;
            apb(0, `OFS_BOOT_START, 0);
            for (int w = 0; w < 2; w++) begin
                st = (w ? 65536 : 32768) - (512 << (3 - c));
                chk(got[w], st, "start");
                chk(vec[w], st, "vector");
            end
            apb(0, `OFS_APP_END, 0);
            for (int w = 0; w < 2; w++) begin
                st = (w ? 65535 : 32767) - (512 << (3 - c));
                chk(got[w], st, "end");
            end
        end
        $display("test fuse table done");
        apb(0, `OFS_STATUS, 0);
        for (int w = 0; w < 2; w++) chk(got[w], w << 4, "status");
        for (int wr = 0; wr < 2; wr++) begin
            apb(wr[0], 12'h024, 32'hffff);
            for (int w = 0; w < 2; w++)
                chk({got_err[w], wr ? 31'h0 : got[w][30:0]}, 32'h80000000,
                    "unmapped");
        end
        for (int i = 0; i < 8; i++) begin
            p = 17'($urandom) & 17'h1fffe;
            apb(1, `OFS_EXT_PAGE, p[16]);
            apb(1, `OFS_POINTER, p[15:0]);
            apb(0, `OFS_PAGE, 0);
            for (int w = 0; w < 2; w++) begin
                st = page_of(w, p);
                chk(got[w], st, "page");
            end
            apb(0, `OFS_WORD, 0);
            for (int w = 0; w < 2; w++)
                chk(got[w], p[7:1], "word");
        end
        $display("test pointer map done");
        m_rww = '{0, 0};
        for (int i = 0; i < 10; i++) begin
            p = t_ptr[i];
            apb(1, `OFS_EXT_PAGE, p[16]);
            apb(1, `OFS_POINTER, p[15:0]);
            for (int w = 0; w < 2; w++) begin
                nr[w] = page_of(w, p) >= (w ? 480 : 224);
                rf[w] = t_op[i] == OP_LOAD ? m_rww[w] && !nr[w] : p[0];
            end
            apb(1, `OFS_COMMAND, t_op[i]);
            repeat (3) @(posedge pclk);
            for (int w = 0; w < 2; w++) begin
                st = !rf[w] && nr[w] && t_op[i] inside {OP_ERASE, OP_WRITE};
                chk(halt[w], st, "halt");
            end
            st = 0;
            do apb(0, `OFS_STATUS, 0);
            while ((got[0][0] | got[1][0]) && ++st < 50);
            chk(st >= 50, 0, "poll limit");
            apb(0, `OFS_STATUS, 0);
            for (int w = 0; w < 2; w++) begin
                if (t_op[i] inside {OP_ERASE, OP_WRITE} && !nr[w] && !rf[w])
                    m_rww[w] = 1;
                if (t_op[i] inside {OP_FILL, OP_REENABLE} && !rf[w])
                    m_rww[w] = 0;
                st = {rf[w][0], 1'b0, m_rww[w][0], 1'b0};
                chk(got[w][3:0], st, "st");
                chk(rwwb[w], m_rww[w], "rww");
                if (!rf[w]) begin
                    chk(f_op[w], t_op[i], "op");
                    chk(f_page[w], page_of(w, p), "fpage");
                    st = t_op[i] == OP_WRITE ? 0 : p[7:1];
                    chk(f_word[w], st, "fword");
                end
            end
            apb(1, `OFS_STATUS, 32'h8);
            apb(0, `OFS_LOAD_DATA, 0);
            for (int w = 0; w < 2; w++) begin
                wv = 16'ha5c3 ^ {p[15:8], 1'b0, p[7:1]};
                if (t_op[i] == OP_LOAD && !rf[w])
                    chk(got[w], p[0] ? wv[15:8] : wv[7:0], "load");
            end
        end
        $display("test flash ops done");
        complete_run();
    end
endmodule

// ==== flash_partner.sv ====
// Purpose: behavioural flash macro facing the decoder
// Assumes: one operation at a time
// Notes: answer time varies from two to seven cycles
`timescale 1ns/1ps
module flash_partner (
    // clock
    input wire logic pclk,
    // request
    input wire logic flash_req,
    input wire logic [8:0] flash_page,
    input wire logic [6:0] flash_word,
    // answer
    output logic flash_done,
    output logic [15:0] flash_rdata
);
    logic [15:0] word_val;
    assign word_val = 16'ha5c3 ^ {flash_page[7:0], 1'b0, flash_word};
    // inverted off the answer cycle so a late sample cannot match
    assign flash_rdata = flash_done ? word_val : ~word_val;
    initial begin
        flash_done = 1'b0;
        forever begin
            @(posedge pclk);
            if (flash_req === 1'b1) begin
                repeat (2 + $urandom % 6) @(posedge pclk);
                flash_done <= 1'b1;
                @(posedge pclk);
                flash_done <= 1'b0;
            end
        end
    end
endmodule

// ==== region_map.sv ====
// Purpose: section bounds and pointer-to-page mapping
// Assumes: wide selects the 64K-word variant
// Notes: purely combinational
`timescale 1ns/1ps
`include "boot_map_defines.svh"
module region_map
    import boot_map_pkg::*;
#(
    parameter bit wide = 1'b0
) (
    region_map_if.map m
);
    function automatic logic [15:0] boot_start_of(input logic [1:0] code);
        logic [15:0] s;
        s = 16'h0000;
        case (code)
            2'b11: s = wide ? `BOOT_64K_3 : `BOOT_32K_3;
            2'b10: s = wide ? `BOOT_64K_2 : `BOOT_32K_2;
            2'b01: s = wide ? `BOOT_64K_1 : `BOOT_32K_1;
            default: s = wide ? `BOOT_64K_0 : `BOOT_32K_0;
        endcase
        return s;
    endfunction

    logic [15:0] pc;

    always_comb begin
        // word address is the pointer shifted by one
        pc = m.pointer[16:1];
        if (!wide) begin
            pc[15] = 1'b0;
        end
    end

    assign m.boot_start = boot_start_of(m.fuse);
    assign m.app_end = boot_start_of(m.fuse) - 16'h0001;
    // page bits above the counter width are dropped
    assign m.page_number = wide ? pc[15:7] : {1'b0, pc[14:7]};
    assign m.word_in_page_index = pc[6:0];
    // fixed 32-page no-read-while-write area, fuse independent
    assign m.in_no_read_while_write_area = wide ? (pc >= `NO_READ_WHILE_WRITE_AREA_START_64K)
                            : (pc >= `NO_READ_WHILE_WRITE_AREA_START_32K);
endmodule

// ==== region_map_if.sv ====
// Purpose: carries pointer and fuse to the region map and its answer
// Assumes: single clock domain, combinational answer
// Notes: none
`timescale 1ns/1ps
interface region_map_if;
    logic [1:0] fuse;
    logic [16:0] pointer;
    logic [15:0] boot_start;
    logic [15:0] app_end;
    logic [8:0] page_number;
    logic [6:0] word_in_page_index;
    logic in_no_read_while_write_area;

    modport req (
        output fuse, pointer,
        input boot_start, app_end, page_number, word_in_page_index,
        input in_no_read_while_write_area
    );
    modport map (
        input fuse, pointer,
        output boot_start, app_end, page_number, word_in_page_index,
        output in_no_read_while_write_area
    );
endinterface
